// ==== hdl/lps_pkg.sv ====
// shared constants for the linear pixel scan sequencer and its controller
package lps_pkg;
  // ----------------------------------------
  // array geometry
  // ----------------------------------------
  localparam int unsigned PIX_COUNT    = 128;   // pixels, one shift stage each
  localparam int unsigned PIX_IDX_W    = 7;     // pixel index width
  localparam int unsigned PIX_W        = 8;     // sampled pixel word width
  localparam int unsigned INTEG_W      = 16;    // integrator accumulator width
  localparam int unsigned FIFO_DEPTH   = 8;     // pixel words buffered at controller
  // ----------------------------------------
  // sequence positions, counted in sensor clock rising edges from the start
  // ----------------------------------------
  localparam int unsigned RST_EDGES    = 18;    // edges with integrators held in reset
  localparam int unsigned RELEASE_EDGE = 19;    // edge that starts the next integration
  localparam int unsigned SCAN_END_EDGE = 129;  // edge that clocks the pulse out
  localparam int unsigned NEXT_START_EDGE = 130; // earliest edge for a new start
  localparam int unsigned EDGE_CNT_W   = 20;    // edge counter width
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CORE_PERIOD_NS = 40;  // core clock period
  localparam int unsigned SCLK_HALF_NS   = 160; // sensor clock high and low time
  localparam int unsigned SCLK_HALF_CYC  = (SCLK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned SCLK_PERIOD_NS = 2 * SCLK_HALF_NS;
  localparam int unsigned INTEG_MIN_NS   = 16000; // shortest integration time
  localparam int unsigned INTEG_MIN_CLKS =
    (INTEG_MIN_NS + SCLK_PERIOD_NS - 1) / SCLK_PERIOD_NS;
  localparam int unsigned INTEG_MAX_MS   = 100;   // longest integration time
  localparam int unsigned INTEG_MAX_CLKS = (INTEG_MAX_MS * 1000000) / SCLK_PERIOD_NS;
  // ----------------------------------------
  // controller states
  // ----------------------------------------
  typedef enum logic [0:0] {
    LPS_IDLE = 1'b0,   // sensor clock stopped low
    LPS_SCAN = 1'b1    // sensor clock running
  } lps_state_t;
endpackage

// ==== hdl/lps_link_if.sv ====
// link between the scan sequencer and its controller
`timescale 1ns/1ns
interface lps_link_if;
  logic       sensor_clk;        // controller-made sensor clock
  logic       scan_start;        // start pulse, one sensor clock long
  logic       sample_freeze;     // freeze, tied to scan_start
  logic [7:0] pixel_analog_out;  // pixel level, valid while enabled
  logic       pixel_out_en;      // high while the device drives the output
  logic       chain_out;         // chain pulse for cascading or end of data

  modport device (
    input  sensor_clk,
    input  scan_start,
    input  sample_freeze,
    output pixel_analog_out,
    output pixel_out_en,
    output chain_out
  );

  modport ctrl (
    output sensor_clk,
    output scan_start,
    output sample_freeze,
    input  pixel_analog_out,
    input  pixel_out_en,
    input  chain_out
  );
endinterface

// ==== hdl/lps_ctrl_end.sv ====
// controller end: sensor clock, start pulse, pixel capture through a fifo
`timescale 1ns/1ns

// ----------------------------------------
// pixel fifo
// ----------------------------------------
module lps_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic [WIDTH-1:0]      o_rd_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];   // storage words
  logic [AW-1:0]    wr_ptr_ff;        // next write slot
  logic [AW-1:0]    rd_ptr_ff;        // next read slot
  logic [AW:0]      cnt_ff;           // words held
  logic             wr_go;            // write accepted
  logic             rd_go;            // read accepted

  assign o_wr_ready = (cnt_ff != (AW+1)'(DEPTH));  // honest full
  assign o_rd_valid = (cnt_ff != '0);               // honest empty
  assign o_rd_data  = mem_ff[rd_ptr_ff];
  assign wr_go      = i_wr_valid && o_wr_ready;
  assign rd_go      = o_rd_valid && i_rd_ready;

  // store written word
  always_ff @(posedge i_core_clk) begin
    if (wr_go) begin
      mem_ff[wr_ptr_ff] <= i_wr_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (wr_go) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (rd_go) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (wr_go && !rd_go) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (rd_go && !wr_go) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------
// controller end
// ----------------------------------------
module lps_ctrl_end #(
  parameter int unsigned INTEG_CLKS = lps_pkg::INTEG_MIN_CLKS  // integration, sensor clocks
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  lps_link_if.ctrl        link,
  input  wire logic       i_scan_req,    // keep scanning while high
  output logic            o_busy,        // sensor clock running
  output logic            o_pix_valid,   // pixel word available
  input  wire logic       i_pix_ready,   // user takes the word
  output logic [7:0]      o_pix_data     // pixel word
);
  localparam int unsigned NEXT_MIN =
    (lps_pkg::RELEASE_EDGE + INTEG_CLKS > lps_pkg::NEXT_START_EDGE) ?
    lps_pkg::RELEASE_EDGE + INTEG_CLKS : lps_pkg::NEXT_START_EDGE;
  localparam int unsigned DIV_W = $clog2(lps_pkg::SCLK_HALF_CYC + 1);

  lps_pkg::lps_state_t              state_ff;   // idle or scanning
  logic [DIV_W-1:0]                 div_ff;     // half period counter
  logic                             sclk_ff;    // sensor clock level
  logic                             start_ff;   // start and freeze level
  logic [lps_pkg::EDGE_CNT_W-1:0]   edge_ff;    // rising edges since start
  logic                             half_end;   // last cycle of a half period
  logic                             sample_pt;  // last cycle before a rise
  logic                             fifo_rdy;   // fifo can take a word
  logic                             stall;      // hold clock low for back-pressure
  logic                             seq_done;   // next start is allowed

  assign half_end  = (div_ff == DIV_W'(lps_pkg::SCLK_HALF_CYC - 1));
  assign sample_pt = half_end && !sclk_ff && (state_ff == lps_pkg::LPS_SCAN);
  assign stall     = sample_pt && link.pixel_out_en && !fifo_rdy;
  assign seq_done  = (edge_ff >= lps_pkg::EDGE_CNT_W'(NEXT_MIN));

  assign link.sensor_clk    = sclk_ff;
  assign link.scan_start    = start_ff;
  assign link.sample_freeze = start_ff;
  assign o_busy             = (state_ff == lps_pkg::LPS_SCAN);

  // pixels captured just before each rising edge
  lps_fifo #(
    .WIDTH (8),
    .DEPTH (lps_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_wr_valid (sample_pt && link.pixel_out_en),
    .o_wr_ready (fifo_rdy),
    .i_wr_data  (link.pixel_analog_out),
    .o_rd_valid (o_pix_valid),
    .i_rd_ready (i_pix_ready),
    .o_rd_data  (o_pix_data)
  );

  // sensor clock divider, paused low when the fifo is full while the pixel output is enabled
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_ff  <= '0;
      sclk_ff <= 1'b0;
    end else if (state_ff == lps_pkg::LPS_IDLE) begin
      div_ff  <= '0;
      sclk_ff <= 1'b0;
    end else if (stall) begin
      div_ff  <= div_ff;                    // keep clock low
    end else if (half_end) begin
      div_ff  <= '0;
      sclk_ff <= !sclk_ff;
    end else begin
      div_ff  <= div_ff + 1'b1;
    end
  end

  // scan sequence: start pulse, edge count, stop after full gap
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= lps_pkg::LPS_IDLE;
      start_ff <= 1'b0;
      edge_ff  <= '0;
    end else begin
      case (state_ff)
        lps_pkg::LPS_IDLE: begin
          if (i_scan_req) begin
            state_ff <= lps_pkg::LPS_SCAN;
            start_ff <= 1'b1;              // set up before first rise
            edge_ff  <= '0;
          end
        end
        lps_pkg::LPS_SCAN: begin
          if (half_end && !sclk_ff && !stall) begin
            // rising edge now
            if (start_ff) begin
              edge_ff <= lps_pkg::EDGE_CNT_W'(1);
            end else if (!seq_done) begin
              edge_ff <= edge_ff + 1'b1;
            end
          end else if (half_end && sclk_ff) begin
            // falling edge: drop start, or launch the next one
            if (start_ff) begin
              start_ff <= 1'b0;
            end else if (seq_done && i_scan_req) begin
              start_ff <= 1'b1;
            end else if (seq_done) begin
              state_ff <= lps_pkg::LPS_IDLE;
            end
          end
        end
        default: begin
          state_ff <= lps_pkg::LPS_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== hdl/lps_sensor_end.sv ====
// device end: 128-stage scan sequencer with integrators and sample stores
`timescale 1ns/1ns
module lps_sensor_end (
  input  wire logic          i_core_clk,
  input  wire logic          i_resetn,
  lps_link_if.device         link,
  input  wire logic [1023:0] i_light_level,   // light per pixel, 8 bits each
  output logic               o_integ_reset,   // integrators held in reset
  output logic               o_scan_active    // readout phase in progress
);
  localparam int unsigned NPIX = lps_pkg::PIX_COUNT;
  localparam int unsigned IW   = lps_pkg::PIX_IDX_W;
  localparam int unsigned PW   = lps_pkg::PIX_W;
  localparam int unsigned GW   = lps_pkg::INTEG_W;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic sclk_s1_ff;      // sensor clock, first stage
  logic sclk_s2_ff;      // sensor clock, second stage
  logic sclk_s3_ff;      // delayed copy for edge detect
  logic start_s1_ff;     // start, first stage
  logic start_s2_ff;     // start, second stage
  logic frz_s1_ff;       // freeze, first stage
  logic frz_s2_ff;       // freeze, second stage
  logic frz_s3_ff;       // delayed copy for edge detect
  logic sclk_rise;       // one core cycle per sensor clock rising edge
  logic frz_rise;        // one core cycle per freeze rising edge

  // pins pass two flops before any logic looks at them
  // a pin edge reaches the logic three core clocks late, so each sensor
  // clock level has to last at least three core clocks to be seen
  // start and freeze are sampled with the clock, so they keep their
  // setup relation to the clock rise through the same two stages
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_s1_ff  <= 1'b0;
      sclk_s2_ff  <= 1'b0;
      sclk_s3_ff  <= 1'b0;
      start_s1_ff <= 1'b0;
      start_s2_ff <= 1'b0;
      frz_s1_ff   <= 1'b0;
      frz_s2_ff   <= 1'b0;
      frz_s3_ff   <= 1'b0;
    end else begin
      sclk_s1_ff  <= link.sensor_clk;
      sclk_s2_ff  <= sclk_s1_ff;
      sclk_s3_ff  <= sclk_s2_ff;
      start_s1_ff <= link.scan_start;
      start_s2_ff <= start_s1_ff;
      frz_s1_ff   <= link.sample_freeze;
      frz_s2_ff   <= frz_s1_ff;
      frz_s3_ff   <= frz_s2_ff;
    end
  end

  assign sclk_rise = sclk_s2_ff && !sclk_s3_ff;
  assign frz_rise  = frz_s2_ff && !frz_s3_ff;

  // ----------------------------------------
  // scan shift register
  // ----------------------------------------
  logic [NPIX-1:0] stage_ff;      // one bit per pixel stage
  logic [NPIX-1:0] nxt_stage;     // stages after this edge
  logic [IW-1:0]   idx_ff;        // pixel on the output
  logic [IW-1:0]   nxt_idx;       // pixel after this edge
  logic            chain_ff;      // chain output level
  logic            out_en_ff;     // output drive enable
  logic [PW-1:0]   out_val_ff;    // output level

  // pulse enters stage 0 and steps one stage per sensor clock
  // a start seen while an older pulse still travels reloads the register:
  // the old pulse is dropped, so only one pixel drives the output and the
  // chain pulse follows the newest start alone, except for a start on the edge that clocks the old pulse out of the last stage
  always_comb begin
    nxt_stage = {stage_ff[NPIX-2:0], start_s2_ff};
    nxt_idx   = idx_ff;                               // hold by default
    if (start_s2_ff) begin
      nxt_stage = NPIX'(1);
      nxt_idx   = '0;                                 // first pixel
    end else if (stage_ff != '0) begin
      nxt_idx = idx_ff + 1'b1;
    end
  end

  // shift register, index and chain output on each sensor clock rising edge
  // chain output copies the last stage, so it rises on the edge that
  // empties the register and falls on the edge after it
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage_ff <= '0;
      idx_ff   <= '0;
      chain_ff <= 1'b0;
    end else if (sclk_rise) begin
      stage_ff <= nxt_stage;
      idx_ff   <= nxt_idx;
      chain_ff <= stage_ff[NPIX-1];
    end
  end

  // ----------------------------------------
  // integrators and sample stores
  // ----------------------------------------
  logic [GW-1:0] integ_ff [NPIX];   // running integrator per pixel
  logic [PW-1:0] store_ff [NPIX];   // frozen sample per pixel
  logic          integ_rst_ff;      // all integrators in reset
  logic [4:0]    rst_cnt_ff;        // sensor edges since freeze

  // reset period runs from freeze to the release edge
  // rst_cnt_ff counts sensor clock rises seen since the freeze; the rise
  // that finds it at the release value is the first one of integration
  // a new freeze wins over the release when both fall in one cycle
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      integ_rst_ff <= 1'b0;
      rst_cnt_ff   <= '0;
    end else if (frz_rise) begin
      integ_rst_ff <= 1'b1;
      rst_cnt_ff   <= '0;
    end else if (sclk_rise && integ_rst_ff) begin
      rst_cnt_ff   <= rst_cnt_ff + 1'b1;
      if (rst_cnt_ff == 5'(lps_pkg::RELEASE_EDGE - 1)) begin
        integ_rst_ff <= 1'b0;
      end
    end
  end

  // per pixel: saturating integrator, store captured on freeze
  // the top bits of the integrator form the stored word, so a saturated
  // integrator reads as full scale
  genvar gi;
  generate
    for (gi = 0; gi < NPIX; gi++) begin : g_pix
      logic [GW:0] sum;   // integrator plus light with carry
      assign sum = {1'b0, integ_ff[gi]} + (GW+1)'(i_light_level[gi*PW +: PW]);

      always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          integ_ff[gi] <= '0;
        end else if (integ_rst_ff || frz_rise) begin
          integ_ff[gi] <= '0;
        end else if (sum[GW]) begin
          integ_ff[gi] <= '1;                         // saturated
        end else begin
          integ_ff[gi] <= sum[GW-1:0];
        end
      end

      always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          store_ff[gi] <= '0;
        end else if (frz_rise) begin
          store_ff[gi] <= integ_ff[gi][GW-1 -: PW];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // pixel output
  // ----------------------------------------
  // driven only while a stage holds the pulse
  // the word is zero while disabled so a reader never sees a stale
  // pixel once the scan has ended
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_en_ff  <= 1'b0;
      out_val_ff <= '0;
    end else if (sclk_rise) begin
      out_en_ff  <= (nxt_stage != '0);
      if (nxt_stage != '0) begin
        out_val_ff <= store_ff[nxt_idx];
      end else begin
        out_val_ff <= '0;
      end
    end
  end

  // ----------------------------------------
  // link and status outputs
  // ----------------------------------------
  // every output below comes straight from a register
  assign link.pixel_analog_out = out_val_ff;
  assign link.pixel_out_en     = out_en_ff;
  assign link.chain_out        = chain_ff;
  assign o_integ_reset         = integ_rst_ff;
  assign o_scan_active         = out_en_ff;
endmodule

// ==== bench/lps_link_monitor.sv ====
// link checker for the scan sequencer and its controller
`timescale 1ns/1ns
module lps_link_monitor (
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  input  wire logic       sensor_clk,
  input  wire logic       scan_start,
  input  wire logic       sample_freeze,
  input  wire logic [7:0] pixel_analog_out,
  input  wire logic       pixel_out_en,
  input  wire logic       chain_out
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic       sclk_q_ff;    // sensor clock one core cycle ago
  logic [7:0] rise_cnt_ff;  // sensor clock rises since last start, saturating

  // remember the sensor clock to find its rises
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_q_ff <= 1'b0;
    end else begin
      sclk_q_ff <= sensor_clk;
    end
  end

  // count rises, a rise with start high is rise one
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rise_cnt_ff <= 8'h00;
    end else if (sensor_clk && !sclk_q_ff && scan_start) begin
      rise_cnt_ff <= 8'h01;
    end else if (sensor_clk && !sclk_q_ff && rise_cnt_ff != 8'hff) begin
      rise_cnt_ff <= rise_cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking mon_cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  AST_FREEZE_TIED: assert property (sample_freeze == scan_start)
    else $error("freeze differs from start");
  AST_START_ONE_CLK: assert property (
    $rose(sensor_clk) && scan_start |-> ##4 !scan_start)
    else $error("start still high at the clock fall");
  AST_OUT_NEEDS_START: assert property ($rose(pixel_out_en) |-> $past(scan_start, 2))
    else $error("output enabled without a start");
  AST_OUT_ON_CLK: assert property (
    ($changed(pixel_analog_out) || $changed(pixel_out_en))
      |-> $past(sensor_clk, 3) && !$past(sensor_clk, 4))
    else $error("output moved away from a clock rise");
  AST_OFF_ZERO: assert property (!pixel_out_en |-> pixel_analog_out == 8'h00)
    else $error("output driven while disabled");
  AST_OUT_EN_SPAN: assert property (
    pixel_out_en |-> rise_cnt_ff != 8'h00 && rise_cnt_ff <= 8'h81)
    else $error("output enabled outside a scan");
  AST_END_AT_129: assert property ($fell(pixel_out_en) |-> rise_cnt_ff == 8'h81)
    else $error("scan ended on the wrong rise");
  AST_CHAIN_WITH_END: assert property ($rose(chain_out) |-> $fell(pixel_out_en))
    else $error("chain pulse apart from end of scan");
  AST_CHAIN_ONE_CLK: assert property (
    $rose(chain_out) |-> chain_out [*4] ##[1:8] !chain_out)
    else $error("chain pulse length wrong");
  AST_NEXT_START_GAP: assert property (
    sensor_clk && !sclk_q_ff && scan_start |-> rise_cnt_ff == 8'h00 || rise_cnt_ff >= 8'h81)
    else $error("start earlier than rise 130");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  AST_COVER_END: cover property ($rose(chain_out));
  AST_COVER_RESTART: cover property (sensor_clk && !sclk_q_ff && scan_start
    && rise_cnt_ff == 8'h82);
  AST_COVER_STALL: cover property ((pixel_out_en && !sensor_clk) [*8]);
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the scan sequencer and its controller
`timescale 1ns/1ns
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic          i_core_clk;   // 25 MHz core clock
  logic          i_resetn;     // async reset, active low
  logic          scan_req;     // keep scanning
  logic          pix_ready;    // user takes words
  logic          busy;         // controller clock running
  logic          pix_valid;    // word waiting
  logic [7:0]    pix_data;     // pixel word
  logic          integ2;       // second device integrators in reset
  logic          active2;      // second device readout running
  logic [1023:0] light;        // light for both devices
  int            miscompares;  // mismatches
  int            checks_done;  // comparisons
  int            cyc;          // cycles run
  int            got;          // words taken from the controller

  lps_link_if link ();   // controller to device
  lps_link_if link2 ();  // bench to second device

  // shortest legal integration; the gap between starts stays 130 clocks
  lps_ctrl_end #(.INTEG_CLKS(lps_pkg::INTEG_MIN_CLKS)) u_lps_ctrl_end (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .link(link.ctrl), .i_scan_req(scan_req), .o_busy(busy),
    .o_pix_valid(pix_valid), .i_pix_ready(pix_ready), .o_pix_data(pix_data));
  lps_sensor_end u_lps_sensor_end (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .link(link.device), .i_light_level(light), .o_integ_reset(), .o_scan_active());
  lps_sensor_end u_lps_sensor_end_b (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .link(link2.device), .i_light_level(light), .o_integ_reset(integ2),
    .o_scan_active(active2));
  lps_link_monitor u_lps_link_monitor (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .sensor_clk(link.sensor_clk), .scan_start(link.scan_start),
    .sample_freeze(link.sample_freeze), .pixel_analog_out(link.pixel_analog_out),
    .pixel_out_en(link.pixel_out_en), .chain_out(link.chain_out));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  // saturating pattern: every third pixel bright
  function automatic logic [7:0] exp_pix(input int p);
    return (p % 3 == 0) ? 8'hff : 8'h00;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  // ----------------------------------------
  // controller and device pair
  // ----------------------------------------
  // take words until the count is reached, pattern from the second scan on
  task automatic stream(input int upto);
    // a word seen just after an edge is taken by the next edge
    while (got < upto) begin
      #1;
      if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
        if (got >= 128) check(pix_data, exp_pix(got % 128));
        got++;
      end
      @(posedge i_core_clk);
    end
  endtask

  // user stalls: fifo fills, sensor clock must stop low
  task automatic stall();
    int high;
    high = 0;
    // entered at the edge that takes the last counted word
    pix_ready <= 1'b0;
    repeat (200) @(posedge i_core_clk);
    repeat (100) begin
      @(posedge i_core_clk);
      #1;
      high += link.sensor_clk;
    end
    check(high, 0);
    check({busy, pix_valid}, 2'h3);
    @(posedge i_core_clk);
    pix_ready <= 1'b1;
  endtask

  // ----------------------------------------
  // bench-driven second device
  // ----------------------------------------
  // one sensor clock with start and freeze tied, optional light flip
  task automatic edge2(input logic st, input logic flip);
    @(posedge i_core_clk);
    link2.scan_start <= st;
    link2.sample_freeze <= st;
    if (flip) light <= ~light;
    repeat (4) @(posedge i_core_clk);
    link2.sensor_clk <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    link2.sensor_clk <= 1'b0;
    link2.scan_start <= 1'b0;
    link2.sample_freeze <= 1'b0;
    #1;
  endtask

  // clocks up to last, restart early at again, judge each pixel step
  task automatic scan2(input int last, input int again, input logic data_on);
    int   j;
    logic inv;
    j = 0;
    inv = 1'b0;
    for (int k = 1; k <= last; k++) begin
      j = (k == again) ? 1 : j + 1;
      if (k == again) inv = 1'b1;
      edge2(k == 1 || k == again, k == 2 && again < last);
      check(link2.pixel_out_en, j <= 128);
      check(active2, j <= 128);
      check(link2.chain_out, j == 129);
      check(integ2, j <= 18);
      if (j == 19) check(integ2, 1'b0);
      if (j > 128) check(link2.pixel_analog_out, 8'h00);
      if (data_on && j <= 128) check(link2.pixel_analog_out, exp_pix(j - 1) ^ {8{inv}});
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  initial begin
    i_resetn = 1'b0;
    scan_req = 1'b0;
    pix_ready = 1'b1;
    miscompares = 0;
    checks_done = 0;
    cyc = 0;
    got = 0;
    link2.sensor_clk = 1'b0;
    link2.scan_start = 1'b0;
    link2.sample_freeze = 1'b0;
    for (int p = 0; p < 128; p++) light[8*p +: 8] = exp_pix(p);
    repeat (6) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    @(posedge i_core_clk);
    #1;
    check({link.sensor_clk, link.scan_start, link.pixel_out_en, link.chain_out}, 4'h0);
    @(posedge i_core_clk);
    scan_req <= 1'b1;
    stream(300);
    stall();
    stream(384);
    @(posedge i_core_clk);
    scan_req <= 1'b0;
    while (busy !== 1'b0) @(posedge i_core_clk);
    repeat (40) @(posedge i_core_clk);
    #1;
    check({link.sensor_clk, link.pixel_out_en, link.chain_out}, 3'h0);
    scan2(130, 999, 1'b0);
    scan2(130, 999, 1'b1);
    // early start at clock 60 on purpose: the scan must begin again at pixel 0
    scan2(190, 60, 1'b1);
    results();
  end
endmodule
